// ### ddr_wmask_pkg.sv
`default_nettype none
package ddr_wmask_pkg;

  // ****************************************************************
  // widths and lane layout
  // ****************************************************************
  localparam int DATA_MAX_W = 36;
  localparam int LANE_MAX   = 4;
  localparam int NIBBLE_W   = 4;
  localparam int BYTE_W     = 9;

  // ****************************************************************
  // organisations (data bits per beat)
  // ****************************************************************
  localparam int ORG_X8  = 8;
  localparam int ORG_X9  = 9;
  localparam int ORG_X18 = 18;
  localparam int ORG_X36 = 36;

  // ****************************************************************
  // burst word offsets and reset values
  // ****************************************************************
  localparam logic                  BURST_WORD0 = 1'b0;
  localparam logic                  BURST_WORD1 = 1'b1;
  localparam logic [DATA_MAX_W-1:0] Q_RESET     = 36'h0_0000_0000;
  localparam logic [LANE_MAX-1:0]   SEL_IDLE_N  = 4'hf;

  // one write data beat as seen at the pins
  typedef struct packed {
    logic [DATA_MAX_W-1:0] data;
    logic [LANE_MAX-1:0]   selN;
  } beat_s;

  typedef enum logic [2:0] {
    RD_IDLE,
    RD_FETCH,
    RD_HOLD,
    RD_SEND0,
    RD_SEND1,
    RD_DRAIN
  } rd_state_e;

endpackage : ddr_wmask_pkg
`default_nettype wire

// ### ddr_sram_array.sv
`timescale 1ns/100ps
`default_nettype none
module ddr_sram_array
  import ddr_wmask_pkg::*;
#(
  parameter int ADDR_W = 9,
  parameter int DATA_W = DATA_MAX_W
) (
  input  wire logic              mclk,
  input  wire logic              wrEn,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [DATA_W-1:0] wrData,
  input  wire logic [DATA_W-1:0] wrMask,
  input  wire logic [ADDR_W-1:0] rdAddr,
  output var  logic [DATA_W-1:0] rdData_reg
);

  // ****************************************************************
  // one storage column per bit, so a masked bit is never touched
  // ****************************************************************
  for (genvar b = 0; b < DATA_W; b++) begin : g_bit
    logic colMem [2**ADDR_W];

    always_ff @(posedge mclk) begin
      if (wrEn && wrMask[b]) begin
        colMem[wrAddr] <= wrData[b];
      end
      rdData_reg[b] <= colMem[rdAddr];
    end
  end

endmodule : ddr_sram_array
`default_nettype wire

// ### ddr_sram_byte_write_mask.sv
// Notes on behaviour
// - x8: both nibble selects low store all eight data bits of the beat.
// - x8: low nibble select only stores bits 3..0; bits 7..4 keep old value.
// - x8: high nibble select only stores bits 7..4; bits 3..0 keep old value.
// - x18: both byte selects low store all eighteen bits of the beat.
// - x18: select 0 only stores bits 8..0; bits 17..9 unaltered.
// - x18: select 1 only stores bits 17..9; bits 8..0 unaltered.
// - all selects high on a beat write nothing, in every organisation.
// - x9: single select low stores nine bits; high leaves location unaltered.
// - x36: all four selects low store all thirty-six bits.
// - x36: select 0 alone stores bits 8..0, leaving bits 35..9 unaltered.
// - x36: selects 1,2,3 gate bits 17..9, 26..18, 35..27 respectively.
// - selects sampled separately per beat; beats of one burst may differ.
// - write data registered on rising edges of both input clocks.
// - read data leave on output clock rises, input clocks in single-clock mode.
// - after reset the device is deselected with data outputs not driven.
// - burst accesses latched address word first, then the next word.
// - write starts with load and read/write low at positive clock rise.
// - beat one at next positive clock rise, beat two at next negative rise.
`timescale 1ns/100ps
`default_nettype none
module ddr_sram_byte_write_mask
  import ddr_wmask_pkg::*;
#(
  parameter int ORG_BITS = ORG_X18,
  parameter int ADDR_W   = 8
) (
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  input  wire logic                  inClkPos,
  input  wire logic                  inClkNeg,
  input  wire logic                  outClkPos,
  input  wire logic                  outClkNeg,
  input  wire logic                  load_n,
  input  wire logic                  readNotWrite,
  input  wire logic [ADDR_W-1:0]     addrIn,
  input  wire logic [DATA_MAX_W-1:0] dataIn,
  input  wire logic                  lane0_write_sel_n,
  input  wire logic                  lane1_write_sel_n,
  input  wire logic                  lane2_write_sel_n,
  input  wire logic                  lane3_write_sel_n,
  input  wire logic                  low_nibble_sel_n,
  input  wire logic                  high_nibble_sel_n,
  output var  logic [DATA_MAX_W-1:0] qData_reg,
  output var  logic                  qOe_reg,
  output var  logic                  singleClk_reg
);

  localparam int LANE_W = (ORG_BITS == ORG_X8) ? NIBBLE_W : BYTE_W;
  localparam int WADDR_W = ADDR_W + 1;

  // ****************************************************************
  // clock pin edge detection
  // ****************************************************************
  logic inPosPrev_reg;
  logic inNegPrev_reg;
  logic outPosPrev_reg;
  logic outNegPrev_reg;
  logic kRise;
  logic kNegRise;
  logic cRise;
  logic cNegRise;
  logic outPosRise;
  logic outNegRise;

  always_ff @(posedge mclk) begin
    inPosPrev_reg  <= inClkPos;
    inNegPrev_reg  <= inClkNeg;
    outPosPrev_reg <= outClkPos;
    outNegPrev_reg <= outClkNeg;
  end

  assign kRise    = inClkPos & ~inPosPrev_reg;
  assign kNegRise = inClkNeg & ~inNegPrev_reg;
  assign cRise    = outClkPos & ~outPosPrev_reg;
  assign cNegRise = outClkNeg & ~outNegPrev_reg;

  // ****************************************************************
  // single-clock strap, caught once just after reset release
  // ****************************************************************
  logic strapDone_reg;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      strapDone_reg <= 1'b0;
      singleClk_reg <= 1'b0;
    end else if (!strapDone_reg) begin
      strapDone_reg <= 1'b1;
      singleClk_reg <= outClkPos & outClkNeg;
    end
  end

  // output edges follow the input pair when the output pair is strapped high
  assign outPosRise = singleClk_reg ? kRise : cRise;
  assign outNegRise = singleClk_reg ? kNegRise : cNegRise;

  // ****************************************************************
  // write sequencing
  // ****************************************************************
  logic              writeCmd;
  logic              readCmd;
  logic              wrPend_reg;
  logic              beat1Pend_reg;
  logic [ADDR_W-1:0] pendAddr_reg;
  logic [ADDR_W-1:0] beatAddr_reg;

  assign writeCmd = kRise & ~load_n & ~readNotWrite;
  assign readCmd  = kRise & ~load_n & readNotWrite;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wrPend_reg    <= 1'b0;
      beat1Pend_reg <= 1'b0;
      pendAddr_reg  <= '0;
      beatAddr_reg  <= '0;
    end else if (kRise) begin
      wrPend_reg    <= writeCmd;
      beat1Pend_reg <= wrPend_reg;
      if (writeCmd) begin
        pendAddr_reg <= addrIn;
      end
      if (wrPend_reg) begin
        beatAddr_reg <= pendAddr_reg;
      end
    end else if (kNegRise) begin
      beat1Pend_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // beat capture and lane mask
  // ****************************************************************
  beat_s                 beat;
  logic                  beat0Go;
  logic                  beat1Go;
  logic                  wrEn;
  logic [WADDR_W-1:0]    wrAddr;
  logic [DATA_MAX_W-1:0] wrMask;
  logic [LANE_MAX-1:0]   laneSelN;

  assign laneSelN = {lane3_write_sel_n, lane2_write_sel_n,
                     lane1_write_sel_n, lane0_write_sel_n};
  // selects are taken from the pins on each beat, never held from beat one
  assign beat.selN = (ORG_BITS == ORG_X8) ?
                     {2'b11, high_nibble_sel_n, low_nibble_sel_n} : laneSelN;
  assign beat.data = dataIn;

  assign beat0Go = kRise & wrPend_reg;
  assign beat1Go = kNegRise & beat1Pend_reg;
  assign wrEn    = beat0Go | beat1Go;
  assign wrAddr  = beat1Go ? {beatAddr_reg, BURST_WORD1} :
                             {pendAddr_reg, BURST_WORD0};

  // each bit is stored only when its lane select is low on this beat
  for (genvar b = 0; b < DATA_MAX_W; b++) begin : g_mask
    if (b < ORG_BITS) begin : g_used
      assign wrMask[b] = ~beat.selN[b / LANE_W];
    end else begin : g_unused
      assign wrMask[b] = 1'b0;
    end
  end

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [WADDR_W-1:0]    rdAddr;
  logic [DATA_MAX_W-1:0] rdData;

  ddr_sram_array #(
    .ADDR_W (WADDR_W),
    .DATA_W (DATA_MAX_W)
  ) u_array (
    .mclk       (mclk),
    .wrEn       (wrEn),
    .wrAddr     (wrAddr),
    .wrData     (beat.data),
    .wrMask     (wrMask),
    .rdAddr     (rdAddr),
    .rdData_reg (rdData)
  );

  // ****************************************************************
  // read path: one burst in flight; reads issued while busy are dropped
  // ****************************************************************
  rd_state_e             rdState_reg;
  rd_state_e             rdState_next;
  logic [ADDR_W-1:0]     rdBase_reg;
  logic [DATA_MAX_W-1:0] word0_reg;
  logic [DATA_MAX_W-1:0] word1_reg;

  assign rdAddr = (rdState_reg == RD_IDLE) ? {addrIn, BURST_WORD0} :
                                             {rdBase_reg, BURST_WORD1};

  always_comb begin
    rdState_next = rdState_reg;
    case (rdState_reg)
      RD_IDLE:  if (readCmd) rdState_next = RD_FETCH;
      RD_FETCH: rdState_next = RD_HOLD;
      RD_HOLD:  if (kRise) rdState_next = RD_SEND0;
      RD_SEND0: if (outNegRise) rdState_next = RD_SEND1;
      RD_SEND1: if (outPosRise) rdState_next = RD_DRAIN;
      RD_DRAIN: if (outPosRise) rdState_next = RD_IDLE;
      default:  rdState_next = RD_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rdState_reg <= RD_IDLE;
      rdBase_reg  <= '0;
      word0_reg   <= Q_RESET;
      word1_reg   <= Q_RESET;
    end else begin
      rdState_reg <= rdState_next;
      if (rdState_reg == RD_IDLE && readCmd) begin
        rdBase_reg <= addrIn;
      end
      if (rdState_reg == RD_FETCH) begin
        word0_reg <= rdData;
      end
      if (rdState_reg == RD_HOLD) begin
        word1_reg <= rdData;
      end
    end
  end

  // outputs are released after reset and stay released when deselected
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      qData_reg <= Q_RESET;
      qOe_reg   <= 1'b0;
    end else if (rdState_reg == RD_SEND0 && outNegRise) begin
      qData_reg <= word0_reg;
      qOe_reg   <= 1'b1;
    end else if (rdState_reg == RD_SEND1 && outPosRise) begin
      qData_reg <= word1_reg;
    end else if (rdState_reg == RD_DRAIN && outPosRise) begin
      qOe_reg   <= 1'b0;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  // helper flags taken straight from the pins, so the beat checks do not
  // lean on the sequencing registers they are meant to watch
  logic              chkWrOpen_reg;
  logic              chkBeat1_reg;
  logic [ADDR_W-1:0] chkWrAddr_reg;
  logic [ADDR_W-1:0] chkBeatAddr_reg;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      chkWrOpen_reg   <= 1'b0;
      chkBeat1_reg    <= 1'b0;
      chkWrAddr_reg   <= '0;
      chkBeatAddr_reg <= '0;
    end else if (kRise) begin
      chkWrOpen_reg   <= ~load_n & ~readNotWrite;
      chkBeat1_reg    <= chkWrOpen_reg;
      chkWrAddr_reg   <= addrIn;
      chkBeatAddr_reg <= chkWrAddr_reg;
    end else if (kNegRise) begin
      chkBeat1_reg <= 1'b0;
    end
  end

  x8_full_a: assert property (ORG_BITS == ORG_X8 && wrEn && !low_nibble_sel_n
      && !high_nibble_sel_n |-> wrMask == 36'h0_0000_00ff)
    else $error("x8 full write mask wrong");
  x8_low_a: assert property (ORG_BITS == ORG_X8 && wrEn && !low_nibble_sel_n
      && high_nibble_sel_n |-> wrMask == 36'h0_0000_000f)
    else $error("x8 low nibble mask wrong");
  x8_high_a: assert property (ORG_BITS == ORG_X8 && wrEn && low_nibble_sel_n
      && !high_nibble_sel_n |-> wrMask == 36'h0_0000_00f0)
    else $error("x8 high nibble mask wrong");
  x18_full_a: assert property (ORG_BITS == ORG_X18 && wrEn && !lane0_write_sel_n
      && !lane1_write_sel_n |-> wrMask == 36'h0_0003_ffff)
    else $error("x18 full write mask wrong");
  x18_low_a: assert property (ORG_BITS == ORG_X18 && wrEn && !lane0_write_sel_n
      && lane1_write_sel_n |-> wrMask == 36'h0_0000_01ff)
    else $error("x18 low byte mask wrong");
  x18_high_a: assert property (ORG_BITS == ORG_X18 && wrEn && lane0_write_sel_n
      && !lane1_write_sel_n |-> wrMask == 36'h0_0003_fe00)
    else $error("x18 high byte mask wrong");
  no_write_a: assert property (wrEn && (&beat.selN) |-> wrMask == '0)
    else $error("masked beat still writes");
  x9_lane_a: assert property (ORG_BITS == ORG_X9 && wrEn
      |-> wrMask == (lane0_write_sel_n ? 36'h0 : 36'h0_0000_01ff))
    else $error("x9 mask wrong");
  x36_full_a: assert property (ORG_BITS == ORG_X36 && wrEn && laneSelN == 4'h0
      |-> wrMask == 36'hf_ffff_ffff)
    else $error("x36 full write mask wrong");
  x36_lane0_a: assert property (ORG_BITS == ORG_X36 && wrEn && laneSelN == 4'he
      |-> wrMask == 36'h0_0000_01ff)
    else $error("x36 lane zero mask wrong");
  x36_upper_a: assert property (ORG_BITS == ORG_X36 && wrEn
      |-> wrMask[17:9] == {9{~lane1_write_sel_n}} && wrMask[26:18] == {9{~lane2_write_sel_n}}
          && wrMask[35:27] == {9{~lane3_write_sel_n}})
    else $error("x36 upper lane mask wrong");
  beat_pair_a: assert property (chkWrOpen_reg && kRise
      |-> wrEn && wrAddr == {chkWrAddr_reg, BURST_WORD0})
    else $error("first beat not taken at next rise");
  second_word_a: assert property (chkBeat1_reg && kNegRise
      |-> wrEn && wrAddr == {chkBeatAddr_reg, BURST_WORD1})
    else $error("second beat not at next word");
  idle_pins_a: assert property (wrEn
      |-> (chkWrOpen_reg && kRise) || (chkBeat1_reg && kNegRise))
    else $error("write without a pending beat");
  out_launch_a: assert property ($rose(qOe_reg) |-> $past(outNegRise))
    else $error("read data launched off output edge");
  reset_quiet_a: assert property ($past(!rst_b) |-> !qOe_reg)
    else $error("outputs driven after reset");

  full_burst_c: cover property (beat0Go && wrMask != '0 ##[1:40] beat1Go && wrMask != '0);
  mixed_sel_c:  cover property (beat0Go && &beat.selN ##[1:40] beat1Go && !(&beat.selN));
  read_out_c:   cover property ($rose(qOe_reg) ##[1:80] $fell(qOe_reg));
  single_clk_c: cover property (singleClk_reg && $rose(qOe_reg));

endmodule : ddr_sram_byte_write_mask
`default_nettype wire

// ### mem_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module mem_ctrl_model
  import ddr_wmask_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       runClk,
  input  wire logic       strapHigh,
  output logic            inClkPos,
  output logic            inClkNeg,
  output logic            outClkPos,
  output logic            outClkNeg,
  output var  logic       load_n,
  output var  logic       readNotWrite,
  output var  logic [7:0] addrIn,
  output var  beat_s      beat
);
  logic       runR = 1'b0;
  logic [1:0] ph   = 2'h0;
  int         syncMiss = 0;

  always @(posedge mclk) begin
    runR <= runClk;
    ph   <= runR ? ph + 2'h1 : 2'h0;
  end

  // stopped clocks park high; the output pair parks at the strap level
  assign inClkPos  = runR ? ~ph[1] : 1'b1;
  assign inClkNeg  = runR ? ph[1] : 1'b1;
  // single-clock mode ties the output pair high for the whole run
  assign outClkPos = (runR && !strapHigh) ? inClkPos : strapHigh;
  assign outClkNeg = (runR && !strapHigh) ? inClkNeg : strapHigh;

  initial begin
    load_n       = 1'b1;
    readNotWrite = 1'b1;
    addrIn       = 8'h00;
    beat         = '{data: '0, selN: SEL_IDLE_N};
  end

  task automatic sync(input logic [1:0] p);
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (ph != p && k < 8);
    if (ph != p) syncMiss++;
  endtask : sync

  // released lines carry the inverse, so a stale value never passes
  task automatic burst(input logic rw, input logic [7:0] a, input beat_s b0, input beat_s b1);
    sync(2'h3);
    load_n       <= 1'b0;
    readNotWrite <= rw;
    addrIn       <= a;
    @(posedge mclk);
    load_n       <= 1'b1;
    readNotWrite <= ~rw;
    addrIn       <= ~a;
    if (!rw) begin
      sync(2'h3);
      beat <= b0;
      sync(2'h1);
      beat <= b1;
      @(posedge mclk);
      beat <= beat_s'(~b1);
    end
  endtask : burst
endmodule : mem_ctrl_model
`default_nettype wire

// ### ddr_sram_byte_write_mask_test.sv
`timescale 1ns/100ps
`default_nettype none
module ddr_sram_byte_write_mask_test
  import ddr_wmask_pkg::*;
;
  localparam int ORGS[4] = '{ORG_X8, ORG_X9, ORG_X18, ORG_X36};
  logic        mclk = 1'b0;
  logic        rst_b, runClk, strapHigh;
  logic        inClkPos, inClkNeg, outClkPos, outClkNeg;
  logic        load_n, readNotWrite;
  logic [7:0]  addrIn;
  beat_s       beat;
  logic [35:0] qData [4];
  logic        qOe [4];
  logic        singleClk [4];
  logic [35:0] refMem [int];
  int          fail_count, n_tests;

  always #12.5 mclk = ~mclk;

  // ******
  // far side and one device per organisation
  // ******
  mem_ctrl_model ctrlModel (.mclk(mclk), .runClk(runClk), .strapHigh(strapHigh),
    .inClkPos(inClkPos), .inClkNeg(inClkNeg), .outClkPos(outClkPos),
    .outClkNeg(outClkNeg), .load_n(load_n), .readNotWrite(readNotWrite),
    .addrIn(addrIn), .beat(beat));

  for (genvar g = 0; g < 4; g++) begin : orgGen
    ddr_sram_byte_write_mask #(.ORG_BITS(ORGS[g]), .ADDR_W(8)) ddr_sram_byte_write_mask_inst (
      .mclk(mclk), .rst_b(rst_b), .inClkPos(inClkPos), .inClkNeg(inClkNeg),
      .outClkPos(outClkPos), .outClkNeg(outClkNeg), .load_n(load_n),
      .readNotWrite(readNotWrite), .addrIn(addrIn), .dataIn(beat.data),
      .lane0_write_sel_n(beat.selN[0]), .lane1_write_sel_n(beat.selN[1]),
      .lane2_write_sel_n(beat.selN[2]), .lane3_write_sel_n(beat.selN[3]),
      .low_nibble_sel_n(beat.selN[0]), .high_nibble_sel_n(beat.selN[1]),
      .qData_reg(qData[g]), .qOe_reg(qOe[g]), .singleClk_reg(singleClk[g]));
  end

  // ******
  // reference model and checks
  // ******
  function automatic logic [35:0] laneMask(input int o, input logic [3:0] s);
    int          lw;
    logic [35:0] m;
    lw = (ORGS[o] == ORG_X8) ? NIBBLE_W : BYTE_W;
    m = '0;
    for (int l = 0; l < ORGS[o] / lw; l++)
      if (!s[l]) m |= ((36'h1 << lw) - 36'h1) << (l * lw);
    return m;
  endfunction : laneMask

  function automatic beat_s rbeat(input logic [3:0] s);
    beat_s b;
    b.data = {4'($urandom()), 32'($urandom())};
    b.selN = s;
    return b;
  endfunction : rbeat

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  task automatic check_word(input logic [35:0] got, input logic [35:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask : check_flag

  task automatic wait_oe(input logic lvl, output int n);
    n = 0;
    while (qOe[0] !== lvl) begin
      @(negedge mclk);
      n++;
      if (n > 20) begin
        fail_count++;
        $display("CHECK FAILED at %0t: output enable wait ran out", $time);
        complete_run();
      end
    end
  endtask : wait_oe

  task automatic check_sync();
    if (ctrlModel.syncMiss != 0) begin
      fail_count++;
      $display("CHECK FAILED at %0t: link clock phase wait ran out", $time);
      complete_run();
    end
  endtask : check_sync

  task automatic reset_dut(input logic strap);
    @(posedge mclk);
    runClk <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b     <= 1'b0;
    strapHigh <= strap;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    @(negedge mclk);
    for (int o = 0; o < 4; o++) begin
      check_word(qData[o], '0);
      check_flag(qOe[o], 1'b0);
    end
    repeat (2) @(negedge mclk);
    for (int o = 0; o < 4; o++) check_flag(singleClk[o], strap);
    @(posedge mclk);
    runClk <= 1'b1;
  endtask : reset_dut

  task automatic write_burst(input logic [7:0] a, input beat_s b0, input beat_s b1);
    logic [35:0] m;
    ctrlModel.burst(1'b0, a, b0, b1);
    check_sync();
    for (int o = 0; o < 4; o++) begin
      m = laneMask(o, b0.selN);
      refMem[o*512 + 2*a] = (refMem[o*512 + 2*a] & ~m) | (b0.data & m);
      m = laneMask(o, b1.selN);
      refMem[o*512 + 2*a + 1] = (refMem[o*512 + 2*a + 1] & ~m) | (b1.data & m);
    end
  endtask : write_burst

  task automatic read_check(input logic [7:0] a);
    int n;
    ctrlModel.burst(1'b1, a, beat_s'('0), beat_s'('0));
    check_sync();
    // enable comes one cycle after the out-neg rise, seven falling edges on
    wait_oe(1'b1, n);
    check_word(36'(n), 36'h7);
    for (int w = 0; w < 2; w++) begin
      for (int o = 0; o < 4; o++) begin
        check_flag(qOe[o], 1'b1);
        check_word(qData[o] & laneMask(o, 4'h0), refMem[o*512 + 2*a + w] & laneMask(o, 4'h0));
      end
      repeat (2) @(negedge mclk);
    end
    wait_oe(1'b0, n);
    check_word(36'(n), 36'h2);
  endtask : read_check

  task automatic run_phase(input int nRand);
    for (int a = 0; a < 8; a++) write_burst(8'(a), rbeat(4'h0), rbeat(4'h0));
    for (int i = 0; i < nRand; i++)
      write_burst(8'($urandom_range(7)), rbeat(4'($urandom())), rbeat(4'($urandom())));
    for (int a = 0; a < 8; a++) read_check(8'(a));
  endtask : run_phase

  // ******
  // main sequence
  // ******
  initial begin
    rst_b      = 1'b0;
    runClk     = 1'b0;
    strapHigh  = 1'b1;
    fail_count = 0;
    n_tests    = 0;
    void'($urandom(74));
    reset_dut(1'b1);
    run_phase(0);
    // every select pattern on beat 0, its complement on beat 1
    for (int i = 0; i < 16; i++) begin
      write_burst(8'(i % 8), rbeat(4'(i)), rbeat(~4'(i)));
      read_check(8'(i % 8));
    end
    run_phase(24);
    // second reset mid-run, this time with the output clock pair in use
    reset_dut(1'b0);
    run_phase(12);
    complete_run();
  end
endmodule : ddr_sram_byte_write_mask_test
`default_nettype wire
